/* verilog/oled_link_defines.svh */
// Constants shared by both ends of the display write link.
`ifndef OLED_LINK_DEFINES_SVH
`define OLED_LINK_DEFINES_SVH
`define ADDR_DEFAULT 8'h78
`define ADDR_ALT 8'h7A
`define CTRL_CONT_BIT 7
`define CTRL_DC_BIT 6
`define MEM_BYTES 1024
`define PAGE_COUNT 8
`define COL_COUNT 128
`define CMD_PAGE_HI 4'hB
`define CMD_COL_LO 4'h0
`define CMD_COL_HI 4'h1
`define LINK_DIV 6
`endif

/* verilog/oled_link_pkg.sv */
// Types used by the display target end of the write link.
package oled_link_pkg;
   typedef enum logic [3:0] {
      BYTE_ADDR = 4'h1,
      BYTE_CTRL = 4'h2,
      BYTE_DATA = 4'h4,
      BYTE_IGNORE = 4'h8
   } byte_role_t;
endpackage : oled_link_pkg

/* verilog/oled_link_if.sv */
// Two-wire link between the bus controller and the display target.
`timescale 1ns/1ps
interface oled_link_if;
   logic scl_o, scl_oe, sda_m_o, sda_m_oe, sda_t_o, sda_t_oe;
   wire scl;
   wire sda;
   // Open-drain lines with pull-ups: low wins whenever anyone drives low.
   assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
   assign sda = ((sda_m_oe && !sda_m_o) || (sda_t_oe && !sda_t_o)) ?
                1'b0 : 1'b1;
   modport target (input scl, input sda, output sda_t_o, output sda_t_oe);
   modport master (input scl, input sda, output scl_o, output scl_oe,
                   output sda_m_o, output sda_m_oe);
endinterface : oled_link_if

/* verilog/oled_i2c_write_port.sv */
// Display target end: two-wire write port, command routing and memory.
`timescale 1ns/1ps
`include "oled_link_defines.svh"
module oled_i2c_write_port #(
   parameter int MEM_BYTES = `MEM_BYTES
) (
   // Clock, reset and enable.
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   // Board strap: high selects the alternate address.
   input wire logic i_addr_alt,
   // Link.
   oled_link_if.target link,
   // Memory read-back port.
   input wire logic [9:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   // Command byte stream.
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_byte,
   // Current write position.
   output logic [2:0] o_page,
   output logic [6:0] o_col,
   output logic o_busy
);
   logic scl_m, scl_s, sda_m, sda_s, scl_d, sda_d;
   oled_link_pkg::byte_role_t role, next_role;
   logic [7:0] shreg, next_shreg;
   logic [3:0] bitcnt, next_bitcnt;
   logic ack, next_ack;
   logic cont, next_cont, dc, next_dc, final_ctrl, next_final_ctrl;
   logic [7:0] my_addr, next_my_addr;
   logic [2:0] page, next_page;
   logic [6:0] col, next_col;
   logic busy, next_busy;
   logic cmd_valid, next_cmd_valid;
   logic [7:0] cmd_byte, next_cmd_byte;
   logic [7:0] rd_data;
   logic [7:0] mem [MEM_BYTES];
   logic mem_we;
   logic [9:0] mem_wa;
   logic start_ev, stop_ev, scl_rise, scl_fall;
   logic [7:0] full;
   logic strap_m, strap_s;

   // Two-stage synchronisers for both link lines.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         strap_m <= 1'b0;
         strap_s <= 1'b0;
      end else if (i_ce) begin
         strap_m <= i_addr_alt;
         strap_s <= strap_m;
         scl_m <= link.scl;
         scl_s <= scl_m;
         sda_m <= link.sda;
         sda_s <= sda_m;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Bus conditions and clock edges from the synchronised lines.
   assign start_ev = scl_s && scl_d && sda_d && !sda_s;
   assign stop_ev = scl_s && scl_d && !sda_d && sda_s;
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign full = {shreg[6:0], sda_s};

   // Byte framing, acknowledge and byte routing.
   always_comb begin
      next_role = role;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_ack = ack;
      next_cont = cont;
      next_dc = dc;
      next_final_ctrl = final_ctrl;
      next_my_addr = my_addr;
      next_page = page;
      next_col = col;
      next_busy = busy;
      next_cmd_valid = 1'b0;
      next_cmd_byte = cmd_byte;
      mem_we = 1'b0;
      mem_wa = {page, col};
      if (!busy && !start_ev) begin
         // Strap caught while the bus is idle, after reset release.
         next_my_addr = strap_s ? `ADDR_ALT : `ADDR_DEFAULT;
      end
      if (start_ev) begin
         next_role = oled_link_pkg::BYTE_ADDR;
         next_bitcnt = 4'h0;
         next_ack = 1'b0;
         next_busy = 1'b1;
         next_final_ctrl = 1'b0;
      end else if (stop_ev) begin
         next_role = oled_link_pkg::BYTE_IGNORE;
         next_ack = 1'b0;
         next_busy = 1'b0;
      end else if (busy && scl_rise && bitcnt < 4'h8) begin
         next_shreg = full;
         next_bitcnt = bitcnt + 4'h1;
         if (bitcnt == 4'h7) begin
            unique case (role)
               oled_link_pkg::BYTE_ADDR: begin
                  if (full == my_addr) begin
                     next_ack = 1'b1;
                  end else begin
                     next_role = oled_link_pkg::BYTE_IGNORE;
                  end
               end
               oled_link_pkg::BYTE_CTRL: begin
                  next_ack = 1'b1;
                  next_cont = full[`CTRL_CONT_BIT];
                  next_dc = full[`CTRL_DC_BIT];
                  next_final_ctrl = !full[`CTRL_CONT_BIT];
               end
               oled_link_pkg::BYTE_DATA: begin
                  next_ack = 1'b1;
                  if (dc) begin
                     mem_we = 1'b1;
                     next_col = col + 7'h01;
                  end else begin
                     next_cmd_valid = 1'b1;
                     next_cmd_byte = full;
                     // Position commands: page, then column low, high.
                     if (full[7:4] == `CMD_PAGE_HI) begin
                        next_page = full[2:0];
                     end else if (full[7:4] == `CMD_COL_LO) begin
                        next_col = {col[6:4], full[3:0]};
                     end else if (full[7:4] == `CMD_COL_HI) begin
                        next_col = {full[2:0], col[3:0]};
                     end
                  end
               end
               oled_link_pkg::BYTE_IGNORE: begin
               end
            endcase
         end
      end else if (busy && scl_rise && bitcnt == 4'h8) begin
         // Ninth pulse is the acknowledge slot, whether we answer or not.
         next_bitcnt = 4'h9;
      end else if (busy && scl_fall && bitcnt == 4'h9) begin
         // Acknowledge slot over: release and move to the next byte.
         next_ack = 1'b0;
         next_bitcnt = 4'h0;
         unique case (role)
            oled_link_pkg::BYTE_ADDR: next_role = oled_link_pkg::BYTE_CTRL;
            oled_link_pkg::BYTE_CTRL: next_role = oled_link_pkg::BYTE_DATA;
            oled_link_pkg::BYTE_DATA: begin
               // Continuation set: one data byte, then control again.
               if (!final_ctrl) begin
                  next_role = oled_link_pkg::BYTE_CTRL;
               end
            end
            oled_link_pkg::BYTE_IGNORE: begin
            end
         endcase
      end
   end

   // Ack is held from the falling clock after bit 8 through the ack pulse.
   logic ack_drive, next_ack_drive;
   always_comb begin
      next_ack_drive = ack_drive;
      if (start_ev || stop_ev) begin
         next_ack_drive = 1'b0;
      end else if (scl_fall && bitcnt == 4'h8 && ack) begin
         next_ack_drive = 1'b1;
      end else if (scl_fall && bitcnt == 4'h9) begin
         next_ack_drive = 1'b0;
      end
   end

   // Register the control state.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         role <= oled_link_pkg::BYTE_IGNORE;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         ack <= 1'b0;
         ack_drive <= 1'b0;
         cont <= 1'b0;
         dc <= 1'b0;
         final_ctrl <= 1'b0;
         my_addr <= `ADDR_DEFAULT;
         page <= 3'h0;
         col <= 7'h00;
         busy <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_byte <= 8'h00;
      end else if (i_ce) begin
         role <= next_role;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         ack <= next_ack;
         ack_drive <= next_ack_drive;
         cont <= next_cont;
         dc <= next_dc;
         final_ctrl <= next_final_ctrl;
         my_addr <= next_my_addr;
         page <= next_page;
         col <= next_col;
         busy <= next_busy;
         cmd_valid <= next_cmd_valid;
         cmd_byte <= next_cmd_byte;
      end
   end

   // Display memory, one bit per pixel, column byte per page.
   always_ff @(posedge i_clk_sys) begin
      if (i_ce && mem_we) begin
         mem[mem_wa] <= full;
      end
      if (i_ce) begin
         rd_data <= mem[i_rd_addr];
      end
   end

   // Outputs straight from flip-flops.
   assign link.sda_t_o = 1'b0;
   assign link.sda_t_oe = ack_drive;
   assign o_rd_data = rd_data;
   assign o_cmd_valid = cmd_valid;
   assign o_cmd_byte = cmd_byte;
   assign o_page = page;
   assign o_col = col;
   assign o_busy = busy;
endmodule : oled_i2c_write_port

/* verilog/oled_i2c_master.sv */
// Bus controller end: sends one write transaction of queued bytes.
`timescale 1ns/1ps
`include "oled_link_defines.svh"
module oled_i2c_master #(
   parameter int DIV = `LINK_DIV
) (
   // Clock, reset and enable.
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   // Link.
   oled_link_if.master link,
   // Byte request: first byte opens with start, last closes with stop.
   input wire logic i_req,
   input wire logic [7:0] i_byte,
   input wire logic i_first,
   input wire logic i_last,
   output logic o_ready,
   output logic o_nack
);
   typedef enum logic [4:0] {
      M_IDLE = 5'h01, M_START = 5'h02, M_BIT = 5'h04,
      M_ACK = 5'h08, M_STOP = 5'h10
   } mstate_t;
   mstate_t st, next_st;
   logic [7:0] sh, next_sh;
   logic [3:0] cnt, next_cnt;
   logic [1:0] ph, next_ph;
   logic [7:0] tick, next_tick;
   logic last, next_last, scl, next_scl, sdl, next_sdl;
   logic rdy, next_rdy, nack, next_nack;
   logic sda_m, sda_s;

   // Synchronise the data line for the acknowledge sample.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end else if (i_ce) begin
         sda_m <= link.sda;
         sda_s <= sda_m;
      end
   end

   // Four phases per bit: low set-up, rise, high hold, fall.
   always_comb begin
      next_st = st; next_sh = sh; next_cnt = cnt; next_ph = ph;
      next_last = last; next_scl = scl; next_sdl = sdl;
      next_rdy = rdy; next_nack = nack;
      next_tick = (tick == 8'(DIV - 1)) ? 8'h00 : tick + 8'h01;
      unique case (st)
         M_IDLE: begin
            next_tick = 8'h00;
            if (i_req && rdy) begin
               next_rdy = 1'b0; next_sh = i_byte; next_last = i_last;
               next_cnt = 4'h0; next_ph = 2'h0;
               next_st = i_first ? M_START : M_BIT;
            end
         end
         M_START: if (tick == 8'(DIV - 1)) begin
            // Pull the clock low a phase after start, before any data moves.
            next_ph = ph + 2'h1;
            if (ph == 2'h0) begin
               next_sdl = 1'b1; // Data falls while clock is high.
            end else begin
               next_scl = 1'b1;
               next_ph = 2'h0;
               next_st = M_BIT;
            end
         end
         M_BIT, M_ACK: if (tick == 8'(DIV - 1)) begin
            next_ph = ph + 2'h1;
            unique case (ph)
               2'h0: begin
                  next_scl = 1'b1; // Keep clock low and set data in the same step.
                  next_sdl = (st == M_ACK) ? 1'b0 : !sh[7];
               end
               2'h1: next_scl = 1'b0;
               2'h2: if (st == M_ACK) next_nack = sda_s;
               2'h3: begin
                  next_scl = 1'b1;
                  if (st == M_ACK) begin
                     next_st = last ? M_STOP : M_IDLE;
                     next_rdy = !last;
                  end else if (cnt == 4'h7) begin
                     next_st = M_ACK;
                  end else begin
                     next_sh = {sh[6:0], 1'b0};
                     next_cnt = cnt + 4'h1;
                  end
               end
            endcase
         end
         M_STOP: if (tick == 8'(DIV - 1)) begin
            next_ph = ph + 2'h1;
            unique case (ph)
               2'h0: next_sdl = 1'b1;
               2'h1: next_scl = 1'b0;
               2'h2: next_sdl = 1'b0; // Data rises, clock high.
               2'h3: begin next_st = M_IDLE; next_rdy = 1'b1; end
            endcase
         end
      endcase
   end

   // Register the controller state.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= M_IDLE; sh <= 8'h00; cnt <= 4'h0; ph <= 2'h0;
         tick <= 8'h00; last <= 1'b0; scl <= 1'b0; sdl <= 1'b0;
         rdy <= 1'b1; nack <= 1'b0;
      end else if (i_ce) begin
         st <= next_st; sh <= next_sh; cnt <= next_cnt; ph <= next_ph;
         tick <= next_tick; last <= next_last; scl <= next_scl;
         sdl <= next_sdl; rdy <= next_rdy; nack <= next_nack;
      end
   end

   // Open-drain drives: enable pulls the line low.
   assign link.scl_o = 1'b0;
   assign link.scl_oe = scl;
   assign link.sda_m_o = 1'b0;
   assign link.sda_m_oe = sdl;
   assign o_ready = rdy;
   assign o_nack = nack;
endmodule : oled_i2c_master

/* dv/oled_link_sva.sv */
// Concurrent checks on the two-wire display link between both ends.
`timescale 1ns/1ps
module oled_link_sva (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // Drives of both ends and the resolved lines.
   input wire logic scl_oe,
   input wire logic sda_m_o,
   input wire logic sda_m_oe,
   input wire logic sda_t_o,
   input wire logic sda_t_oe,
   input wire scl,
   input wire sda
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // The target may move its drive only while the clock line is low.
   a_tgt_quiet_high: assert property (
      scl && $past(scl) |-> $stable(sda_t_oe))
      else $error("target changed data with clock high");
   // A data fall under a high clock comes from the controller alone.
   a_start_by_master: assert property (
      scl && $past(scl) && $fell(sda) |-> sda_m_oe && !sda_m_o && !sda_t_oe)
      else $error("start not made by the controller");
   // A data rise under a high clock is the controller letting go.
   a_stop_by_master: assert property (
      scl && $past(scl) && $rose(sda) |-> $past(sda_m_oe) && !sda_t_oe)
      else $error("stop not made by the controller");
   // The acknowledge pulls the data line low.
   a_ack_drive_low: assert property (
      sda_t_oe |-> !sda_t_o && !sda)
      else $error("acknowledge does not hold data low");
   // The acknowledge starts in a low clock phase.
   a_ack_from_low: assert property (
      $rose(sda_t_oe) |-> !scl)
      else $error("acknowledge started with clock high");
   // The acknowledge covers the next clock pulse and then ends.
   a_ack_spans_pulse: assert property (
      $rose(sda_t_oe) |-> sda_t_oe throughout (##[1:30] $rose(scl)))
      else $error("acknowledge dropped before the clock pulse");
   a_ack_bounded: assert property (
      $rose(sda_t_oe) |-> ##[1:60] !sda_t_oe)
      else $error("acknowledge held too long");
   // Each low clock phase lasts five system clocks at least.
   a_scl_low_min: assert property (
      $fell(scl) |-> !scl [*5])
      else $error("clock low phase too short");
   // Both lines are released when reset ends.
   a_idle_after_rst: assert property (
      $rose(i_rstn) |-> scl && sda && !sda_t_oe && !scl_oe)
      else $error("lines not idle after reset");
endmodule : oled_link_sva

/* dv/testbench.sv */
// Self-checking bench joining the link controller to the display port.
`timescale 1ns/1ps
module testbench;
   logic clk, rstn, req, first, last, ready, nack, strap, cmd_valid, busy;
   logic [7:0] tx, rd_data, cmd_byte, wire_byte;
   logic [9:0] rd_addr;
   logic [2:0] page;
   logic [6:0] col;
   int mismatches, checked, nbits;
   logic [7:0] cmds[$];
   oled_link_if link ();
   oled_i2c_master u_oled_i2c_master (.i_clk_sys(clk), .i_rstn(rstn),
      .i_ce(1'b1), .link(link), .i_req(req), .i_byte(tx), .i_first(first),
      .i_last(last), .o_ready(ready), .o_nack(nack));
   oled_i2c_write_port u_oled_i2c_write_port (.i_clk_sys(clk),
      .i_rstn(rstn), .i_ce(1'b1), .i_addr_alt(strap), .link(link),
      .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_cmd_valid(cmd_valid),
      .o_cmd_byte(cmd_byte), .o_page(page), .o_col(col), .o_busy(busy));
   oled_link_sva u_oled_link_sva (.i_clk_sys(clk), .i_rstn(rstn),
      .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o),
      .sda_m_oe(link.sda_m_oe), .sda_t_o(link.sda_t_o),
      .sda_t_oe(link.sda_t_oe), .scl(link.scl), .sda(link.sda));
   // Makes the system clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Collects every command byte that the port hands out.
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) cmds.push_back(cmd_byte);
   end
   // Rebuilds the first byte after each start from the wire itself.
   always @(negedge link.sda) begin
      if (link.scl === 1'b1) nbits = 0;
   end
   always @(posedge link.scl) begin
      nbits++;
      if (nbits <= 8) wire_byte = {wire_byte[6:0], link.sda};
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Hands one byte to the controller and waits for it to finish.
   task automatic send(input logic [7:0] b, input logic f, input logic l,
      output logic nk);
      int n;
      n = 0;
      @(negedge clk);
      while (ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      req = 1'b1;
      tx = b;
      first = f;
      last = l;
      @(negedge clk);
      req = 1'b0;
      n = 0;
      while (ready !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      nk = nack;
   endtask : send
   // Sends a whole transaction; returns the answer to the address byte.
   task automatic xfer(input logic [7:0] q[$], output logic nk0);
      logic nk;
      for (int i = 0; i < q.size(); i++) begin
         send(q[i], i == 0, i == q.size() - 1, nk);
         if (i == 0) nk0 = nk;
      end
   endtask : xfer
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd_addr = a;
      @(negedge clk);
      chk(rd_data, exp);
   endtask : rd
   task automatic t_idle;
      chk({link.scl, link.sda}, 2'b11);
      chk({busy, page, col}, 11'h000);
   endtask : t_idle
   // Sets the position near the page end and writes across the wrap.
   task automatic t_pixels;
      logic nk;
      cmds.delete();
      xfer('{8'h78, 8'h00, 8'hB7, 8'h0E, 8'h17}, nk);
      chk(nk, 1'b0);
      chk(wire_byte, 8'h78);
      chk(10'(cmds.size()), 10'h003);
      chk({page, col}, {3'h7, 7'h7E});
      chk({busy, link.scl, link.sda}, 3'b011);
      xfer('{8'h78, 8'h40, 8'hA5, 8'h5A, 8'h3C}, nk);
      chk(10'(cmds.size()), 10'h003);
      rd(10'h3FE, 8'hA5);
      rd(10'h3FF, 8'h5A);
      rd(10'h380, 8'h3C);
      chk(col, 7'h01);
   endtask : t_pixels
   // Alternates control and single bytes under a set continuation bit.
   task automatic t_cont;
      logic nk;
      cmds.delete();
      xfer('{8'h78, 8'h80, 8'hB2, 8'hC0, 8'h11, 8'h00, 8'hB6}, nk);
      chk(10'(cmds.size()), 10'h002);
      chk(cmds[0], 8'hB2);
      chk(cmds[1], 8'hB6);
      chk(page, 3'h6);
      rd(10'h101, 8'h11);
   endtask : t_cont
   // Checks both strap settings and the ignored transactions.
   task automatic t_strap;
      logic nk;
      cmds.delete();
      xfer('{8'h7A, 8'h00, 8'hB1}, nk);
      chk(nk, 1'b1);
      chk({10'(cmds.size()), page}, 13'h0006);
      @(negedge clk);
      strap = 1'b1;
      xfer('{8'h7A, 8'h00, 8'hB4}, nk);
      chk({nk, page}, 4'h4);
      xfer('{8'h78, 8'h00, 8'hB3}, nk);
      chk({nk, page}, 4'hC);
      @(negedge clk);
      strap = 1'b0;
   endtask : t_strap
   // Resets in mid-transfer, then checks that a new write still works.
   task automatic t_reset;
      logic nk;
      @(negedge clk);
      req = 1'b1;
      tx = 8'h78;
      first = 1'b1;
      last = 1'b0;
      repeat (40) @(negedge clk);
      chk(busy, 1'b1);
      rstn = 1'b0;
      req = 1'b0;
      repeat (2) @(negedge clk);
      chk({busy, page, col, link.scl, link.sda}, 13'h0003);
      rstn = 1'b1;
      xfer('{8'h78, 8'h00, 8'hB5}, nk);
      chk({nk, page}, 4'h5);
   endtask : t_reset
   task automatic end_sim;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   // Cuts a hung run short well after the tests should have ended.
   initial begin
      #100000;
      mismatches++;
      end_sim;
   end
   // Resets both ends, then runs the scenarios in turn.
   initial begin
      rstn = 1'b0;
      req = 1'b0;
      tx = 8'h00;
      first = 1'b0;
      last = 1'b0;
      strap = 1'b0;
      rd_addr = 10'h000;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      t_idle;
      t_pixels;
      t_cont;
      t_strap;
      t_reset;
      end_sim;
   end
endmodule : testbench
